// ---- verilog/tit_top.v ----
// Purpose: Totalizer, interval timer and spare counter with a register port.
// Assumes: One 50 MHz clock; the phase clock is made by a rate accumulator.
// Notes: Registers are 16 bits wide and reached by word index.
//
// How it works
// - three independent sixteen-bit counters
// - totalizer counts down per selected source edge
// - totalizer wrap raises shared interrupt
// - interval counter divides phase clock 61440
// - interval end raises shared interrupt
// - interval output toggles each period
// - spare counter wired to option pins
// - select bit picks raw or debounced
// - mismatch enables prescaler and shifter
// - prescaler divides system clock by 256
// - matched register stops prescaler and shifter
// - early input change clears and preloads
// - only stable input passes debouncer
// - two bits choose input threshold
`include "tit_defs.vh"
`default_nettype none

module tit_top #(
    parameter WIDTH = 16,
    parameter STAGES = `TIT_DEB_STAGES
) (
    input wire clk_in,
    input wire srst_in,
    input wire [3:0] addr_in,
    input wire [WIDTH-1:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [WIDTH-1:0] rdata_out,
    input wire tot_pin_in,
    input wire spare_clk_in,
    output reg spare_out,
    output reg ivl_wave_out,
    output reg [1:0] thresh_sel_out,
    output reg timer_interrupt_n_out
);

    // ****************************************
    // Derived timing
    // ****************************************
    // Interval length in phase ticks, from the period and rate.
    localparam [31:0] IVL_TICKS = `TIT_ECLK_HZ / 32'd1000 * `TIT_IVL_US / 32'd1000;
    // Reload value of the interval counter.
    localparam [WIDTH-1:0] IVL_RELOAD = `TIT_IVL_DIV - 16'h0001;
    // Debounce span in phase ticks per stage, not used by the logic.
    localparam [31:0] DEB_TICKS = `TIT_ECLK_HZ / 32'd1000 * `TIT_DEB_NS / 32'd1000000 / STAGES;
    // Prescaler ratio held at its own width, so that its low byte can be sliced.
    localparam [8:0] DEB_DIV = `TIT_DEB_DIV;
    // Last prescaler count before a shift, one below the ratio.
    localparam [7:0] PRE_LAST = DEB_DIV[7:0] - 8'h01;
    // Control reset value at its own width, so that the threshold pair can be sliced.
    localparam [2:0] CTRL_RST = `TIT_CTRL_RST;

    // ****************************************
    // Phase clock tick
    // ****************************************
    reg [31:0] phase_acc; // Rate accumulator.
    reg phase_tick; // One-cycle tick at the phase rate.
    wire [31:0] acc_sum; // Accumulator plus step.

    assign acc_sum = phase_acc + `TIT_ECLK_HZ;

    // The tick fires on average 1228800 times a second.
    always @(posedge clk_in) begin
        if (srst_in) begin
            phase_acc <= 32'h00000000;
            phase_tick <= 1'b0;
        end else if (acc_sum >= `TIT_CLK_HZ) begin
            phase_acc <= acc_sum - `TIT_CLK_HZ;
            phase_tick <= 1'b1;
        end else begin
            phase_acc <= acc_sum;
            phase_tick <= 1'b0;
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    reg [1:0] tot_sync; // Totalizer pin stages.
    reg [1:0] spare_sync; // Spare clock pin stages.
    wire tot_raw; // Raw conditioned totalizer level.
    wire spare_lvl; // Spare clock level.

    // Two flip-flops before anything reads a pin.
    always @(posedge clk_in) begin
        if (srst_in) begin
            tot_sync <= 2'b00;
            spare_sync <= 2'b00;
        end else begin
            tot_sync <= {tot_sync[0], tot_pin_in};
            spare_sync <= {spare_sync[0], spare_clk_in};
        end
    end

    assign tot_raw = tot_sync[1];
    assign spare_lvl = spare_sync[1];

    // ****************************************
    // Debouncer
    // ****************************************
    reg [STAGES-1:0] deb_sr; // Shift register, last stage is the output.
    reg [7:0] deb_pre; // Prescaler of the phase tick.
    reg raw_prev; // Raw level one cycle back.
    wire mismatch; // Raw input differs from last stage.
    wire raw_edge; // Raw input changed this cycle.

    assign mismatch = tot_raw ^ deb_sr[STAGES-1];
    assign raw_edge = tot_raw ^ raw_prev;

    // A mismatch runs the prescaler; its wrap shifts the register.
    always @(posedge clk_in) begin
        if (srst_in) begin
            deb_sr <= {STAGES{1'b0}};
            deb_pre <= 8'h00;
            raw_prev <= 1'b0;
        end else begin
            raw_prev <= tot_raw;
            if (raw_edge) begin
                // Early change restarts the whole interval.
                deb_pre <= 8'h00;
                deb_sr <= {STAGES{deb_sr[STAGES-1]}};
            end else if (mismatch && phase_tick) begin
                // Divide by 256 then shift in the raw level.
                if (deb_pre == PRE_LAST) begin
                    deb_pre <= 8'h00;
                    deb_sr <= {deb_sr[STAGES-2:0], tot_raw};
                end else begin
                    deb_pre <= deb_pre + 8'h01;
                end
            end else if (!mismatch) begin
                // Matched: prescaler held clear, register frozen.
                deb_pre <= 8'h00;
            end
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    reg [2:0] ctrl; // Source select and threshold pair.
    wire wr_ctrl; // Write to control.
    wire wr_tot; // Write to totalizer preload.
    wire wr_stat; // Write-one-to-clear of status.
    wire wr_mask; // Write to mask.

    assign wr_ctrl = wr_in && (addr_in == `TIT_REG_CTRL);
    assign wr_tot = wr_in && (addr_in == `TIT_REG_TOT);
    assign wr_stat = wr_in && (addr_in == `TIT_REG_STAT);
    assign wr_mask = wr_in && (addr_in == `TIT_REG_MASK);

    // Latch bits written by the processor.
    always @(posedge clk_in) begin
        if (srst_in) begin
            ctrl <= `TIT_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl <= wdata_in[2:0];
        end
    end

    // Threshold pair drives the divider: 00 2.5 V, 01 0.7 V, 10 1.4 V, 11 0.7 V.
    always @(posedge clk_in) begin
        if (srst_in) begin
            thresh_sel_out <= CTRL_RST[`TIT_CTRL_THR+1:`TIT_CTRL_THR];
        end else begin
            thresh_sel_out <= ctrl[`TIT_CTRL_THR+1:`TIT_CTRL_THR];
        end
    end

    // ****************************************
    // Totalizing counter
    // ****************************************
    reg [WIDTH-1:0] tot_cnt; // Down counter value.
    reg tot_clk_prev; // Selected source one cycle back.
    wire tot_clk; // Selected totalizer clock.
    wire tot_step; // Rising edge of the selected clock.
    wire tot_wrap; // Step taken from zero.

    // Low picks the raw input, high the debounced one.
    assign tot_clk = ctrl[`TIT_CTRL_SRC] ? deb_sr[STAGES-1] : tot_raw;
    // The gate is always open, so every rising edge counts.
    assign tot_step = tot_clk && !tot_clk_prev;
    assign tot_wrap = tot_step && (tot_cnt == {WIDTH{1'b0}});

    // Preload by write; a write wins over a step in the same cycle.
    always @(posedge clk_in) begin
        if (srst_in) begin
            tot_cnt <= {WIDTH{1'b0}};
            tot_clk_prev <= 1'b0;
        end else begin
            tot_clk_prev <= tot_clk;
            if (wr_tot) begin
                tot_cnt <= wdata_in;
            end else if (tot_step) begin
                tot_cnt <= tot_cnt - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    // ****************************************
    // Interval counter
    // ****************************************
    reg [WIDTH-1:0] ivl_cnt; // Down counter of phase ticks.
    wire ivl_end; // Last tick of a period.

    // Its own clock and gate inputs are idle, so the phase tick drives it.
    assign ivl_end = phase_tick && (ivl_cnt == {WIDTH{1'b0}});

    // Counts 61440 ticks per period and reloads itself.
    always @(posedge clk_in) begin
        if (srst_in) begin
            ivl_cnt <= IVL_RELOAD;
            ivl_wave_out <= 1'b0;
        end else if (ivl_end) begin
            ivl_cnt <= IVL_RELOAD;
            ivl_wave_out <= !ivl_wave_out;
        end else if (phase_tick) begin
            ivl_cnt <= ivl_cnt - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // ****************************************
    // Spare counter
    // ****************************************
    reg [WIDTH-1:0] spare_cnt; // Free down counter on the option clock.
    reg spare_prev; // Spare clock one cycle back.

    // No internal duty: it counts option clock edges and toggles its pin.
    always @(posedge clk_in) begin
        if (srst_in) begin
            spare_cnt <= {WIDTH{1'b1}};
            spare_prev <= 1'b0;
            spare_out <= 1'b0;
        end else begin
            spare_prev <= spare_lvl;
            if (spare_lvl && !spare_prev) begin
                spare_cnt <= spare_cnt - {{(WIDTH-1){1'b0}}, 1'b1};
                if (spare_cnt == {WIDTH{1'b0}}) begin
                    spare_out <= !spare_out;
                end
            end
        end
    end

    // ****************************************
    // Interrupt status and mask
    // ****************************************
    reg [1:0] stat; // Sticky event flags.
    reg [1:0] mask; // Enables onto the shared line.
    wire [1:0] stat_set; // Events of this cycle.

    assign stat_set = {ivl_end, tot_wrap};

    // Status value after this cycle's clear and set; a set wins over a clear.
    function [1:0] next_stat_view;
        input [1:0] cur;
        input [1:0] set;
        input clr_en;
        input [1:0] clr;
        begin
            next_stat_view = (cur & ~(clr_en ? clr : 2'b00)) | set;
        end
    endfunction

    // A set in the clearing cycle wins over the clear.
    always @(posedge clk_in) begin
        if (srst_in) begin
            stat <= `TIT_ST_RST;
        end else begin
            stat <= next_stat_view(stat, stat_set, wr_stat, wdata_in[1:0]);
        end
    end

    // Mask register, one enable per flag.
    always @(posedge clk_in) begin
        if (srst_in) begin
            mask <= `TIT_ST_RST;
        end else if (wr_mask) begin
            mask <= wdata_in[1:0];
        end
    end

    // Shared active-low line, low while any enabled flag stands.
    always @(posedge clk_in) begin
        if (srst_in) begin
            timer_interrupt_n_out <= 1'b1;
        end else begin
            timer_interrupt_n_out <= ~|(next_stat_view(stat, stat_set, wr_stat, wdata_in[1:0]) & mask);
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    reg [WIDTH-1:0] next_rdata; // Selected read word.

    // Unmapped indexes read as zero.
    always @* begin
        next_rdata = {WIDTH{1'b0}};
        case (addr_in)
            `TIT_REG_CTRL: begin
                next_rdata = {{(WIDTH-3){1'b0}}, ctrl};
            end
            `TIT_REG_TOT: begin
                next_rdata = tot_cnt;
            end
            `TIT_REG_IVL: begin
                next_rdata = ivl_cnt;
            end
            `TIT_REG_SPARE: begin
                next_rdata = spare_cnt;
            end
            `TIT_REG_STAT: begin
                next_rdata = {{(WIDTH-2){1'b0}}, stat};
            end
            `TIT_REG_MASK: begin
                next_rdata = {{(WIDTH-2){1'b0}}, mask};
            end
            default: begin
                next_rdata = {WIDTH{1'b0}};
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always @(posedge clk_in) begin
        if (srst_in) begin
            rdata_out <= {WIDTH{1'b0}};
        end else if (rd_in) begin
            rdata_out <= next_rdata;
        end else begin
            rdata_out <= {WIDTH{1'b0}};
        end
    end

endmodule // tit_top

`default_nettype wire

// ---- verilog/tit_defs.vh ----
// Purpose: Constants of the totalizer and interval timer block.
// Assumes: Register addresses are word indexes on the plain port.
// Notes: Times are kept in their own unit beside the counts.
`ifndef TIT_DEFS_VH
`define TIT_DEFS_VH

// ****************************************
// Clocking
// ****************************************
// Main clock rate in hertz.
`define TIT_CLK_HZ 32'd50000000
// Phase and system clock rate in hertz.
`define TIT_ECLK_HZ 32'd1228800

// ****************************************
// Timing
// ****************************************
// Interval divide ratio of the phase clock.
`define TIT_IVL_DIV 16'hF000
// Interval period in microseconds.
`define TIT_IVL_US 50000
// Debounce prescaler ratio.
`define TIT_DEB_DIV 9'h100
// Debounce interval in nanoseconds.
`define TIT_DEB_NS 1562500
// Shift register stages of the debouncer.
`define TIT_DEB_STAGES 8

// ****************************************
// Register indexes
// ****************************************
`define TIT_REG_CTRL 4'h0
`define TIT_REG_TOT 4'h1
`define TIT_REG_IVL 4'h2
`define TIT_REG_SPARE 4'h3
`define TIT_REG_STAT 4'h4
`define TIT_REG_MASK 4'h5

// ****************************************
// Fields and reset values
// ****************************************
// Control bit that picks the debounced source.
`define TIT_CTRL_SRC 0
// Low bit of the threshold select pair.
`define TIT_CTRL_THR 1
// Control reset value, threshold pattern 10.
`define TIT_CTRL_RST 3'h4
// Status bit of the totalizer wrap.
`define TIT_ST_TOT 0
// Status bit of the interval end.
`define TIT_ST_IVL 1
// Status and mask reset value.
`define TIT_ST_RST 2'h0

`endif

// ---- tb/tit_top_asserts.sv ----
// Purpose: Port checks for the totalizer and interval timer block.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Bound to tit_top below the module.
`default_nettype none
module tit_chk #(parameter WIDTH = 16, parameter STAGES = 8) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [3:0] addr_in,
    input wire logic [WIDTH-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [WIDTH-1:0] rdata_out,
    input wire logic tot_pin_in,
    input wire logic spare_clk_in,
    input wire logic spare_out,
    input wire logic ivl_wave_out,
    input wire logic [1:0] thresh_sel_out,
    input wire logic timer_interrupt_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    // ****************************************
    // Properties
    // ****************************************
    // Reset leaves every output in its idle state.
    property p_rst;
        disable iff (1'b0) srst_in |=> timer_interrupt_n_out && !ivl_wave_out && !spare_out
            && thresh_sel_out == 2'b10 && rdata_out == 0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_idle_rd;
        !rd_in |=> rdata_out == 0;
    endproperty
    a_idle_rd: assert property (p_idle_rd) else $error("read data without read");
    property p_thr_set;
        wr_in && addr_in == 4'h0 |=> ##1 thresh_sel_out == $past(wdata_in[2:1], 2);
    endproperty
    a_thr_set: assert property (p_thr_set) else $error("threshold not taken");
    property p_thr_hold;
        !(wr_in && addr_in == 4'h0) |=> ##1 $stable(thresh_sel_out);
    endproperty
    a_thr_hold: assert property (p_thr_hold) else $error("threshold moved");
    property p_wave;
        $changed(ivl_wave_out) |=> $stable(ivl_wave_out) [*8];
    endproperty
    a_wave: assert property (p_wave) else $error("wave toggles too fast");
    property p_unmask;
        wr_in && addr_in == 4'h5 && wdata_in[1:0] == 2'b00 |-> ##[1:2] timer_interrupt_n_out;
    endproperty
    a_unmask: assert property (p_unmask) else $error("masked interrupt still low");
    property p_unmapped;
        rd_in && addr_in > 4'h5 |=> rdata_out == 0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_stat_w;
        rd_in && addr_in == 4'h4 |=> rdata_out[WIDTH-1:2] == 0;
    endproperty
    a_stat_w: assert property (p_stat_w) else $error("status high bits set");
    property p_spare;
        $stable(spare_clk_in) [*8] |-> $stable(spare_out);
    endproperty
    a_spare: assert property (p_spare) else $error("spare out moved without clock");
    // Main scenarios reached.
    c_irq: cover property (!timer_interrupt_n_out);
    c_thr: cover property (thresh_sel_out == 2'b11);
    c_rd: cover property (rd_in && addr_in == 4'h1);
endmodule // tit_chk
bind tit_top tit_chk #(.WIDTH(WIDTH), .STAGES(STAGES)) u_chk (.clk_in(clk_in), .srst_in(srst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .tot_pin_in(tot_pin_in), .spare_clk_in(spare_clk_in), .spare_out(spare_out),
    .ivl_wave_out(ivl_wave_out), .thresh_sel_out(thresh_sel_out),
    .timer_interrupt_n_out(timer_interrupt_n_out));
`default_nettype wire

// ---- tb/tit_pulse_src.sv ----
// Purpose: Model of the external pulse sources feeding the block.
// Assumes: Levels change just after a rising clock edge.
// Notes: The source has no gate, so counting is never held off.
`default_nettype none
module tit_pulse_src (
    input wire logic clk_in,
    output var logic tot_pin_out,
    output var logic spare_clk_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Both sources idle low.
    initial begin // Totalizer pin and spare clock outputs start low
        tot_pin_out = 1'b0;
        spare_clk_out = 1'b0;
    end
    // Sets the totalizer input to a level and keeps it.
    task set_tot(input logic v);
        @(posedge clk_in);
        tot_pin_out <= v;
    endtask
    // One high pulse on the totalizer input, then low time.
    task pulse_tot(input int hi, input int lo);
        set_tot(1'b1);
        repeat (hi) @(posedge clk_in);
        tot_pin_out <= 1'b0;
        repeat (lo) @(posedge clk_in);
    endtask
    // One rising edge on the spare clock.
    task pulse_spare;
        @(posedge clk_in);
        spare_clk_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        spare_clk_out <= 1'b0;
        repeat (8) @(posedge clk_in);
    endtask
endmodule // tit_pulse_src
`default_nettype wire

// ---- tb/tit_top_test.sv ----
// Purpose: Self-checking bench of the totalizer and interval timer.
// Assumes: 50 MHz clock, reset held five cycles.
// Notes: The full interval period is too long to wait for.
`default_nettype none
module tit_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, srst_in, wr_in, rd_in;
    logic [3:0] addr_in;
    logic [15:0] wdata_in, rv, a, b;
    wire [15:0] rdata_out;
    wire tot_pin, spare_clk, spare_out, ivl_wave_out, irq_n;
    wire [1:0] thresh_sel_out;
    int err_count = 0;
    int n_tests = 0;
    tit_pulse_src src (.clk_in(clk_in), .tot_pin_out(tot_pin), .spare_clk_out(spare_clk));
    tit_top DUT (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .tot_pin_in(tot_pin),
        .spare_clk_in(spare_clk), .spare_out(spare_out), .ivl_wave_out(ivl_wave_out),
        .thresh_sel_out(thresh_sel_out), .timer_interrupt_n_out(irq_n));
    // 20 ns clock.
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task wr(input logic [3:0] ad, input logic [15:0] d);
        @(posedge clk_in);
        addr_in <= ad;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task rd(input logic [3:0] ad, output logic [15:0] d);
        @(posedge clk_in);
        addr_in <= ad;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task rchk(input logic [3:0] ad, input logic [15:0] e, input string nm);
        rd(ad, rv);
        chk(nm, e, rv);
    endtask
    // Lets the interrupt output settle before looking.
    task irq_is(input logic e);
        repeat (2) @(posedge clk_in);
        #1 chk("irq", {15'h0, e}, {15'h0, irq_n});
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        srst_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 4'h0;
        wdata_in = 16'h0000;
        repeat (5) @(posedge clk_in);
        srst_in <= 1'b0;
        chk("thresh", 16'h0002, {14'h0, thresh_sel_out});
        chk("wave", 16'h0000, {15'h0, ivl_wave_out});
        chk("spare out", 16'h0000, {15'h0, spare_out});
        irq_is(1'b1);
        rchk(4'h0, 16'h0004, "ctrl");
        rchk(4'h1, 16'h0000, "tot");
        rchk(4'h3, 16'hFFFF, "spare");
        rchk(4'h4, 16'h0000, "stat");
        rchk(4'h5, 16'h0000, "mask");
        rchk(4'h6, 16'h0000, "unmapped");
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(4'h0, {13'h0, i[1:0], 1'b0});
            @(posedge clk_in);
            #1 chk("thresh", {14'h0, i[1:0]}, {14'h0, thresh_sel_out});
        end
        wr(4'h0, 16'h0004);
        rd(4'h2, a);
        repeat (1000) @(posedge clk_in);
        rd(4'h2, b);
        chk("ivl range", 16'h0001, {15'h0, a <= 16'hEFFF});
        chk("ivl step", 16'h0001, {15'h0, (a - b == 16'd24) || (a - b == 16'd25)});
        $display("test threshold and interval done");
        wr(4'h1, 16'h0002);
        wr(4'h5, 16'h0001);
        repeat (2) src.pulse_tot(4, 8);
        rchk(4'h1, 16'h0000, "tot at zero");
        irq_is(1'b1);
        src.pulse_tot(4, 8);
        rchk(4'h1, 16'hFFFF, "tot wrap");
        rchk(4'h4, 16'h0001, "stat wrap");
        irq_is(1'b0);
        wr(4'h5, 16'h0000);
        irq_is(1'b1);
        wr(4'h5, 16'h0001);
        irq_is(1'b0);
        wr(4'h4, 16'h0001);
        irq_is(1'b1);
        rchk(4'h4, 16'h0000, "stat clear");
        src.pulse_spare();
        rchk(4'h3, 16'hFFFE, "spare step");
        $display("test totalizer done");
        wr(4'h0, 16'h0005);
        wr(4'h1, 16'h0010);
        src.pulse_tot(12000, 8);
        rchk(4'h1, 16'h0010, "glitch");
        src.set_tot(1'b1);
        repeat (77000) @(posedge clk_in);
        rchk(4'h1, 16'h0010, "early");
        for (int k = 0; k < 20 && rv === 16'h0010; k++) begin
            repeat (500) @(posedge clk_in);
            rd(4'h1, rv);
        end
        chk("debounced", 16'h000F, rv);
        rchk(4'h1, 16'h000F, "single step");
        $display("test debounce done");
        give_verdict();
    end
endmodule // tit_top_test
`default_nettype wire
